// ### hdl/dac_level_control.sv
/*
  Digital control of the 9-bit level converter: control register,
  level register pair with transfer on high write, pin override.
  Assumes a classic Wishbone master on the core clock, synchronous reset.
*/
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dac_level_control
  import dac_level_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pin_digital_i,
  output logic converter_on_o,
  output logic pin_drive_enable_o,
  output logic pin_digital_read_o,
  output dac_level_pkg::source_sel_t positive_source_select_o,
  output logic [8:0] level_code_o
);
  logic [7:0] control_reg;
  logic [7:0] high_reg;
  logic [7:0] low_reg;
  logic [8:0] level_reg;
  logic [8:0] formed_code;
  logic bus_req;
  logic wr_strobe;
  logic [31:0] read_next;

  // write decode shared by the register and transfer processes
  function automatic logic write_hit(input logic strobe, input logic [3:0] adr, input logic [3:0] target);
    return strobe && (adr == target);
  endfunction

  // one-cycle answer; the gap drops ack for a cycle, so a held request is acked every other cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_strobe = bus_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // control register; sleep is outside this block so only reset and control writes change it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_reg <= REG_RESET; // RULE_11
    end else if (write_hit(wr_strobe, wb_adr_i, ADDR_CONTROL)) begin
      control_reg <= wb_dat_i[7:0] & CONTROL_MASK; // RULE_13 RULE_12
    end
  end

  // level register pair, low kept to its implemented bits per format
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_reg <= REG_RESET;
      low_reg <= REG_RESET;
    end else if (write_hit(wr_strobe, wb_adr_i, ADDR_LEVEL_HIGH)) begin
      high_reg <= wb_dat_i[7:0];
    end else if (write_hit(wr_strobe, wb_adr_i, ADDR_LEVEL_LOW)) begin
      if (control_reg[RESULT_FORMAT_BIT]) begin
        low_reg <= wb_dat_i[7:0];
      end else begin
        low_reg <= wb_dat_i[7:0] & LEFT_LOW_MASK; // RULE_13
      end
    end
  end

  dac_code_former u_former (
    .high_i(wb_dat_i[7:0]),
    .low_i(low_reg),
    .right_just_i(control_reg[RESULT_FORMAT_BIT]), // RULE_03
    .code_o(formed_code)
  );

  // transfer only on high writes; a low write waits for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_reg <= CODE_RESET; // RULE_11
    end else if (write_hit(wr_strobe, wb_adr_i, ADDR_LEVEL_HIGH)) begin
      level_reg <= formed_code; // RULE_05 RULE_07
    end
  end

  // read mux, unmapped addresses read zero but still ack
  always_comb begin
    read_next = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_CONTROL: read_next[7:0] = control_reg;
      ADDR_LEVEL_HIGH: read_next[7:0] = high_reg;
      ADDR_LEVEL_LOW: read_next[7:0] = low_reg;
      ADDR_LEVEL_STATUS: read_next[8:0] = level_reg;
      default: read_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= read_next;
    end
  end

  // analog-facing outputs, registered one cycle behind the control state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      converter_on_o <= 1'b0;
      pin_drive_enable_o <= 1'b0;
      positive_source_select_o <= SRC_SUPPLY;
      level_code_o <= CODE_RESET;
      pin_digital_read_o <= 1'b0;
    end else begin
      converter_on_o <= control_reg[CONVERTER_ON_BIT]; // RULE_01
      pin_drive_enable_o <= control_reg[PIN_DRIVE_ENABLE_BIT]; // RULE_08
      positive_source_select_o <= source_sel_t'(control_reg[SOURCE_MSB:SOURCE_LSB]); // RULE_10
      level_code_o <= level_reg;
      // the input detector is cut off while the pin carries the reference
      pin_digital_read_o <= pin_digital_i & ~control_reg[PIN_DRIVE_ENABLE_BIT]; // RULE_09
    end
  end
endmodule
`default_nettype wire

// ### hdl/dac_level_pkg.sv
/*
  Constants for the converter level control block: register offsets,
  control field positions, reset values and source selection codes.
  Assumes a 32-bit classic Wishbone slave with one aligned word per register.
*/
// Summary of operation
// RULE_01 - the converter is active only while control bit 7 (converter_on) is set.
// RULE_02 - the level code is 9 bits wide; left justified, high holds code 8:1 and low bit 7 holds code 0.
// RULE_03 - control bit 6 (result_format) selects right justified when one, left justified when zero.
// RULE_04 - right justified, code bit 8 is high bit 0 and code bits 7:0 are the whole low register.
// RULE_05 - a write to the high register transfers the register pair into the active level buffer.
// RULE_06 - software writes the low register before the high register.
// RULE_07 - writing the low register alone never changes the active level.
// RULE_08 - control bit 5 (pin_drive_enable) routes the converter voltage to the pin and overrides its digital driver.
// RULE_09 - while the pin carries the reference voltage, its digital read returns zero.
// RULE_10 - control bits 3:2 select the positive source: 11 fixed reference, 10 reference pin, 01 amplifier, 00 supply.
// RULE_11 - reset disables the converter, frees the pin and clears the level code and all control fields.
// RULE_12 - wake from sleep leaves the control register unchanged.
// RULE_13 - unimplemented control and left-justified low bits ignore writes and read as zero; low bits 6:0 written under right justified still read back.
package dac_level_pkg;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_LEVEL_HIGH = 4'h4;
  localparam logic [3:0] ADDR_LEVEL_LOW = 4'h8;
  localparam logic [3:0] ADDR_LEVEL_STATUS = 4'hC;
  localparam int CONVERTER_ON_BIT = 7;
  localparam int RESULT_FORMAT_BIT = 6;
  localparam int PIN_DRIVE_ENABLE_BIT = 5;
  localparam int SOURCE_LSB = 2;
  localparam int SOURCE_MSB = 3;
  localparam int CODE_WIDTH = 9;
  localparam logic [7:0] CONTROL_MASK = 8'hEC;
  localparam logic [7:0] LEFT_LOW_MASK = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [8:0] CODE_RESET = 9'h000;
  typedef enum logic [1:0] {
    SRC_SUPPLY = 2'h0,
    SRC_AMPLIFIER = 2'h1,
    SRC_REF_PIN = 2'h2,
    SRC_FIXED_REF = 2'h3
  } source_sel_t;
endpackage

// ### hdl/dac_code_former.sv
/*
  Forms the 9-bit level code from the high and low register pair
  according to the result format. Purely combinational.
  Assumes the caller registers the result at the transfer moment.
*/
`timescale 1ns/1ps
`default_nettype none
module dac_code_former
  import dac_level_pkg::*;
(
  input wire logic [7:0] high_i,
  input wire logic [7:0] low_i,
  input wire logic right_just_i,
  output logic [8:0] code_o
);
  // right justified takes high bit 0 over the whole low byte
  always_comb begin
    if (right_just_i) begin
      code_o = {high_i[0], low_i}; // RULE_04
    end else begin
      code_o = {high_i, low_i[7]}; // RULE_02
    end
  end
endmodule
`default_nettype wire

// ### verif/dac_level_monitor.sv
/* checker on the level control ports
   assumes binding onto the design top with sel always full */
`timescale 1ns/1ps
`default_nettype none
module dac_level_monitor
  import dac_level_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic converter_on_o,
  input wire logic pin_drive_enable_o,
  input wire logic pin_digital_read_o,
  input wire dac_level_pkg::source_sel_t positive_source_select_o,
  input wire logic [8:0] level_code_o
);
  logic tk, wc, hw;
  // taken writes; outputs lag the register by one cycle, hence ##2
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wc = tk && wb_we_i && wb_adr_i == ADDR_CONTROL;
  assign hw = tk && wb_we_i && wb_adr_i == ADDR_LEVEL_HIGH;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; tk |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_on; wc |-> ##2 converter_on_o == $past(wb_dat_i[7], 2); endproperty
  a_on: assert property (p_on) else $error("enable");
  property p_oe; wc |-> ##2 pin_drive_enable_o == $past(wb_dat_i[5], 2); endproperty
  a_oe: assert property (p_oe) else $error("pin drive");
  property p_src; wc |-> ##2 positive_source_select_o == $past(wb_dat_i[3:2], 2); endproperty
  a_src: assert property (p_src) else $error("source");
  property p_pin; pin_drive_enable_o && $past(pin_drive_enable_o) |-> !pin_digital_read_o; endproperty
  a_pin: assert property (p_pin) else $error("pin read");
  property p_hold; $changed(level_code_o) |-> $past(hw, 2); endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_ctl; $changed(converter_on_o) |-> $past(wc, 2); endproperty
  a_ctl: assert property (p_ctl) else $error("control moved");
  property p_rst; $past(rst_i) |-> level_code_o == 0 && !converter_on_o && !pin_drive_enable_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/* bench for the level control block with a register model
   assumes the checker is bound below */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dac_level_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pin = 0, pin_q = 0, ack, on, oe, rd;
  logic [3:0] adr = 0;
  logic [31:0] dat = 0, q;
  source_sel_t src;
  logic [8:0] code, m = 0;
  logic [7:0] c, h, l;
  int error_cnt = 0, cmp_count = 0, cyc_n = 0;
  always #12.5 clk_i = ~clk_i;
  // random pin level and hang guard
  always @(posedge clk_i) begin
    pin <= 1'($urandom);
    pin_q <= pin;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  dac_level_control DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .pin_digital_i(pin),
    .converter_on_o(on), .pin_drive_enable_o(oe), .pin_digital_read_o(rd),
    .positive_source_select_o(src), .level_code_o(code));
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; q keeps read data afterwards
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_i); while (!ack);
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    void'($urandom(51));
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk({on, oe, src, code}, 0);
    // every source code under both formats
    for (int i = 0; i < 12; i++) begin
      c = 8'($urandom);
      c[3:2] = 2'(i);
      c[6] = i[2];
      c[5] = i[0];
      h = 8'($urandom);
      l = 8'($urandom);
      wb(1, ADDR_CONTROL, c);
      wb(0, ADDR_CONTROL, 0);
      chk(q, c & CONTROL_MASK);
      chk({on, oe, src}, {c[7], c[5], c[3:2]});
      // pin read lags the pin by one edge, so look mid-cycle
      @(negedge clk_i);
      chk(rd, pin_q & ~c[5]);
      @(posedge clk_i);
      wb(1, ADDR_LEVEL_LOW, l);
      chk(code, m);
      wb(1, ADDR_LEVEL_HIGH, h);
      m = c[6] ? {h[0], l} : {h, l[7]};
      chk(code, m);
      wb(0, ADDR_LEVEL_HIGH, 0);
      chk(q, h);
      wb(0, ADDR_LEVEL_STATUS, 0);
      chk(q, m);
      wb(0, ADDR_LEVEL_LOW, 0);
      chk(q, c[6] ? l : l & LEFT_LOW_MASK);
    end
    // second reset in mid-run must clear the loaded state
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    m = 0;
    @(posedge clk_i);
    chk({on, oe, src, code}, 0);
    wb(0, ADDR_CONTROL, 0);
    chk(q, 0);
    finish_test();
  end
endmodule
bind dac_level_control dac_level_monitor u_mon (.*);
`default_nettype wire
